// ===== src/pafl_port_mux.sv
// shared port pin alternate functions: bus, selects, irqs, port 6
`timescale 1ns/1ps
`include "pafl_map.svh"
module pafl_port_mux
	import pafl_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic phase2High,
	input wire logic [7:0] busControl,
	input wire pafl_cpu_t cpu,
	input wire logic [7:0] port2In,
	output logic [15:0] addrOut,
	output logic addrOe,
	output logic [7:0] dataOut,
	output logic dataOe,
	input wire logic p3SelWrite,
	input wire logic [7:0] p3SelData,
	input wire logic [7:0] port3Data,
	output logic [7:0] port3Out,
	output logic [7:0] port3SelectReg,
	input wire logic [7:0] port4In,
	input wire logic [7:0] port5In,
	input wire pafl_flags_t irqEnable,
	input wire pafl_flags_t flagClear,
	input wire logic cpuIrqDisable,
	output pafl_flags_t irqFlags,
	output logic irqRequest,
	output logic nmiPulse,
	input wire logic [7:0] asyncCtrl,
	input wire logic [7:0] port6Data,
	input wire logic [7:0] port6Dir,
	input wire logic [7:0] port6In,
	input wire logic uartTx,
	input wire logic timerATimeout,
	input wire logic tokenChainDrive,
	input wire logic sendRequest,
	input wire logic messageBusy,
	input wire logic ackDrive,
	output logic [7:0] port6Out,
	output logic [7:0] port6Oe,
	output logic uartRx,
	output logic timerACountPulse,
	output logic chainGrant,
	output logic tokenLineIn
);
	logic extBus;
	logic emu;
	logic [7:0] csHitN;
	logic [7:0] selEff;
	logic selLoaded;
	logic [6:0] riseIn;
	logic [4:0] fallIn;
	logic [1:0] levelIn;
	logic [6:0] risePrev;
	logic [4:0] fallPrev;
	logic nmiPrev;
	logic tinPrev;
	logic timerWave;
	logic [15:0] next_addrOut;
	logic [7:0] next_dataOut;
	logic next_dataOe;
	pafl_flags_t next_irqFlags;

	// chip select block decode, one 8 kbyte block per select
	function automatic logic csHit(input logic [2:0] idx,
		input logic [15:0] addr);
		csHit = (addr[15:`PAFL_CS_SHIFT] == idx);
	endfunction : csHit

	assign extBus = busControl[`PAFL_BCR_EXT0] & busControl[`PAFL_BCR_EXT7];
	assign emu = busControl[`PAFL_BCR_EMU];
	assign riseIn = {port5In[6:4], port5In[1:0], port4In[5:4]};
	assign fallIn = {port5In[7], port5In[3:2], port4In[7:6]};
	assign levelIn = port4In[2:1];

	// address and data bus drive
	always_comb
	begin
		next_addrOut = cpu.addr;
		if (extBus && !emu && cpu.internal)
		begin
			next_addrOut = `PAFL_ADDR_ONES;
		end
		next_dataOut = cpu.wdata;
		next_dataOe = 1'b0;
		if (emu && cpu.valid && cpu.internal)
		begin
			next_dataOut = cpu.write ? cpu.wdata : cpu.rdata;
			next_dataOe = 1'b1;
		end
		else if (extBus && !emu && cpu.internal)
		begin
			next_dataOut = `PAFL_DATA_ONES;
			next_dataOe = 1'b1;
		end
		else if ((extBus || emu) && cpu.valid && cpu.write)
		begin
			// floats through phase low so a slow device can let go
			next_dataOe = phase2High;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			addrOut <= 16'h0000;
			addrOe <= 1'b0;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
		end
		else
		begin
			addrOut <= next_addrOut;
			addrOe <= extBus | emu;
			dataOut <= next_dataOut;
			dataOe <= next_dataOe;
		end
	end

	// port 3 select register; bit seven caught after reset release
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port3SelectReg <= `PAFL_P3SEL_RST;
			selLoaded <= 1'b0;
		end
		else if (!selLoaded)
		begin
			port3SelectReg[`PAFL_CS7] <= busControl[`PAFL_BCR_EXT7];
			selLoaded <= 1'b1;
		end
		else if (p3SelWrite)
		begin
			port3SelectReg <= p3SelData;
		end
	end

	assign selEff = port3SelectReg |
		{busControl[`PAFL_BCR_EXT7], 7'h00};

	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			csHitN[i] = ~csHit(3'(i), cpu.addr);
			if (i >= `PAFL_CS_FIRST_CLOCKED && !phase2High)
			begin
				csHitN[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port3Out <= `PAFL_P3DATA_RST;
		end
		else
		begin
			port3Out <= (selEff & csHitN) | (~selEff & port3Data);
		end
	end

	// pin samples for edge detection
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			risePrev <= 7'h00;
			fallPrev <= 5'h1f;
			nmiPrev <= 1'b1;
			tinPrev <= 1'b1;
		end
		else
		begin
			risePrev <= riseIn;
			fallPrev <= fallIn;
			nmiPrev <= port4In[`PAFL_NMI_PIN];
			tinPrev <= port6In[`PAFL_P6_TIN];
		end
	end

	// hardware set beats a same-cycle software clear
	always_comb
	begin
		next_irqFlags.rise = (irqFlags.rise & ~flagClear.rise) |
			(riseIn & ~risePrev);
		next_irqFlags.fall = (irqFlags.fall & ~flagClear.fall) |
			(~fallIn & fallPrev);
		next_irqFlags.level = (irqFlags.level & ~flagClear.level) |
			({2{busControl[`PAFL_BCR_IRQSEL]}} & ~levelIn);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irqFlags <= '0;
			irqRequest <= 1'b0;
			nmiPulse <= 1'b0;
		end
		else
		begin
			irqFlags <= next_irqFlags;
			irqRequest <= (|(next_irqFlags & irqEnable)) & ~cpuIrqDisable;
			nmiPulse <= busControl[`PAFL_BCR_IRQSEL] & nmiPrev &
				~port4In[`PAFL_NMI_PIN];
		end
	end

	// port 6 functions
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			timerWave <= 1'b0;
		end
		else if (timerATimeout)
		begin
			timerWave <= ~timerWave;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port6Out <= 8'h00;
			port6Oe <= 8'h00;
			uartRx <= 1'b1;
			timerACountPulse <= 1'b0;
			chainGrant <= 1'b0;
			tokenLineIn <= 1'b1;
		end
		else
		begin
			port6Out <= port6Data;
			port6Oe <= port6Dir;
			if (asyncCtrl[`PAFL_ASYNC_CTRL_STATUS_REGISTER_RX])
			begin
				port6Oe[`PAFL_P6_RX] <= 1'b0;
			end
			if (asyncCtrl[`PAFL_ASYNC_CTRL_STATUS_REGISTER_TX])
			begin
				port6Out[`PAFL_P6_TX] <= uartTx;
				port6Oe[`PAFL_P6_TX] <= 1'b1;
			end
			port6Out[`PAFL_P6_TIMER_A_WAVE_OUTPUT] <= timerWave ^ timerATimeout;
			port6Oe[`PAFL_P6_TIMER_A_WAVE_OUTPUT] <= 1'b1;
			port6Out[`PAFL_P6_TOKEN_CHAIN_OUTPUT] <= tokenChainDrive;
			port6Oe[`PAFL_P6_TOKEN_CHAIN_OUTPUT] <= 1'b1;
			// open drain: only ever pulls low
			port6Out[`PAFL_P6_SHARED_SERIAL_LINE] <= 1'b0;
			port6Oe[`PAFL_P6_SHARED_SERIAL_LINE] <= (sendRequest & ~messageBusy) |
				ackDrive;
			port6Oe[`PAFL_P6_TIN] <= 1'b0;
			port6Oe[`PAFL_P6_TOKEN_CHAIN_INPUT] <= 1'b0;
			uartRx <= port6In[`PAFL_P6_RX];
			// counts low pulses; source must stay under half rate
			timerACountPulse <= tinPrev & ~port6In[`PAFL_P6_TIN];
			chainGrant <= port6In[`PAFL_P6_TOKEN_CHAIN_INPUT];
			tokenLineIn <= port6In[`PAFL_P6_SHARED_SERIAL_LINE];
		end
	end

	property p_addr_ones;
		@(posedge clk) disable iff (!arst_n)
		(extBus && !emu && cpu.internal) |=> (addrOut == 16'hffff);
	endproperty
	a_addr_ones: assert property (p_addr_ones)
		else $error("address not all ones on internal access");

	property p_emu_trace;
		@(posedge clk) disable iff (!arst_n)
		(emu && cpu.valid) |=> (addrOe && addrOut == $past(cpu.addr));
	endproperty
	a_emu_trace: assert property (p_emu_trace)
		else $error("emulation address not traced");

	property p_data_ones;
		@(posedge clk) disable iff (!arst_n)
		(extBus && !emu && cpu.internal) |=> (dataOe && dataOut == 8'hff);
	endproperty
	a_data_ones: assert property (p_data_ones)
		else $error("data not all ones on internal access");

	property p_emu_data;
		@(posedge clk) disable iff (!arst_n)
		(emu && cpu.valid && cpu.internal && !cpu.write) |=>
			(dataOe && dataOut == $past(cpu.rdata));
	endproperty
	a_emu_data: assert property (p_emu_data)
		else $error("internal read data not shown in emulation");

	property p_data_float;
		@(posedge clk) disable iff (!arst_n)
		(!phase2High && !cpu.internal) |=> !dataOe;
	endproperty
	a_data_float: assert property (p_data_float)
		else $error("data driven in phase low on external cycle");

	property p_rise_flag;
		@(posedge clk) disable iff (!arst_n)
		(!riseIn[0] ##1 riseIn[0]) |=> irqFlags.rise[0];
	endproperty
	a_rise_flag: assert property (p_rise_flag)
		else $error("rising edge flag not set");

	property p_fall_quiet;
		@(posedge clk) disable iff (!arst_n)
		(!irqFlags.fall[0] && !(fallPrev[0] && !fallIn[0])) |=>
			!irqFlags.fall[0];
	endproperty
	a_fall_quiet: assert property (p_fall_quiet)
		else $error("falling flag set without falling edge");

	property p_irq_gate;
		@(posedge clk) disable iff (!arst_n)
		irqRequest |-> !$past(cpuIrqDisable);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("request while interrupts disabled");

	property p_level_hold;
		@(posedge clk) disable iff (!arst_n)
		(busControl[6] && !levelIn[0])[*2] |=> irqFlags.level[0];
	endproperty
	a_level_hold: assert property (p_level_hold)
		else $error("level flag dropped while pin low");

	property p_cs7_auto;
		@(posedge clk) disable iff (!arst_n)
		(busControl[7] && phase2High && cpu.addr[15:13] == 3'h7) |=>
			!port3Out[7];
	endproperty
	a_cs7_auto: assert property (p_cs7_auto)
		else $error("select seven not driven");

	property p_clocked_cs;
		@(posedge clk) disable iff (!arst_n)
		(!phase2High && selEff[4]) |=> port3Out[4];
	endproperty
	a_clocked_cs: assert property (p_clocked_cs)
		else $error("clocked select active in phase low");

	property p_timer_a_wave_output;
		@(posedge clk) disable iff (!arst_n)
		timerATimeout |=> port6Out[3] != $past(port6Out[3]);
	endproperty
	a_timer_a_wave_output: assert property (p_timer_a_wave_output)
		else $error("timer output did not toggle");
endmodule : pafl_port_mux

// ===== src/pafl_map.svh
// constants for the port alternate function logic
`ifndef PAFL_MAP_SVH
`define PAFL_MAP_SVH
`define PAFL_BCR_EXT0 0
`define PAFL_BCR_EMU 3
`define PAFL_BCR_IRQSEL 6
`define PAFL_BCR_EXT7 7
`define PAFL_CS_SHIFT 13
`define PAFL_CS_FIRST_CLOCKED 3
`define PAFL_CS7 7
`define PAFL_P6_RX 0
`define PAFL_P6_TX 1
`define PAFL_P6_TIN 2
`define PAFL_P6_TIMER_A_WAVE_OUTPUT 3
`define PAFL_P6_TOKEN_CHAIN_INPUT 4
`define PAFL_P6_TOKEN_CHAIN_OUTPUT 5
`define PAFL_P6_SHARED_SERIAL_LINE 6
`define PAFL_P3SEL_RST 8'h00
`define PAFL_P3DATA_RST 8'hff
`define PAFL_ADDR_ONES 16'hffff
`define PAFL_DATA_ONES 8'hff
`define PAFL_NMI_PIN 0
`define PAFL_ASYNC_CTRL_STATUS_REGISTER_RX 5
`define PAFL_ASYNC_CTRL_STATUS_REGISTER_TX 0
`endif

// ===== src/pafl_pkg.sv
// types shared by the port alternate function logic
package pafl_pkg;
	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic write;
		logic internal;
		logic valid;
	} pafl_cpu_t;
	typedef struct packed
	{
		logic [6:0] rise;
		logic [4:0] fall;
		logic [1:0] level;
	} pafl_flags_t;
endpackage : pafl_pkg

// ===== verif/pafl_ext_model.sv
// far-side pin model for port 6: serial, timer and token bus lines
`timescale 1ns/1ps
module pafl_ext_model
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] port6Out,
	input wire logic [7:0] port6Oe,
	input wire logic rxBit,
	input wire logic extPull,
	output logic [7:0] port6In
);
	logic [1:0] tinCount;
	// count input runs at a quarter of clk, safely under half rate
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tinCount <= 2'h2; // idle high: no false fall at reset
		else
			tinCount <= tinCount + 2'h1;
	end
	always_comb
	begin
		// released pins float up to the pull-up level
		port6In = port6Out | ~port6Oe;
		port6In[0] = rxBit;
		port6In[2] = tinCount[1];
		port6In[4] = 1'b1;
		// open-drain line: any party pulling low wins
		port6In[6] = !(port6Oe[6] && !port6Out[6]) && !extPull;
	end
endmodule : pafl_ext_model

// ===== verif/tb_top.sv
// self-checking testbench for the port alternate function logic
`timescale 1ns/1ps
module tb_top;
	import pafl_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic phase2High = 1'b0;
	logic [7:0] busControl = 8'h81;
	pafl_cpu_t cpu = '0;
	logic p3SelWrite = 1'b0;
	logic [7:0] p3SelData = 8'h00;
	logic [7:0] port3Data = 8'ha5;
	logic [7:0] port4In = 8'hcf;
	logic [7:0] port5In = 8'h8c;
	pafl_flags_t irqEnable = '1;
	pafl_flags_t flagClear = '0;
	logic cpuIrqDisable = 1'b0, rxBit = 1'b1, extPull = 1'b0;
	logic [7:0] asyncCtrl = 8'h21;
	logic [7:0] port6Dir = 8'hff;
	logic uartTx = 1'b0, timerATimeout = 1'b0, sendRequest = 1'b0;
	logic messageBusy = 1'b0, ackDrive = 1'b0;
	logic [15:0] addrOut;
	logic addrOe, dataOe, irqRequest, nmiPulse, uartRx, timerACountPulse;
	logic chainGrant, tokenLineIn;
	logic [7:0] dataOut, port3Out, port3SelectReg, port6Out, port6Oe, port6In;
	pafl_flags_t irqFlags;
	logic [7:0] exp;
	int fails = 0;
	int cmp_count = 0;
	int cnt;
	always #25 clk = ~clk;
	pafl_port_mux uut (.clk, .arst_n, .phase2High, .busControl, .cpu,
		.port2In(8'h00), .addrOut, .addrOe, .dataOut, .dataOe, .p3SelWrite,
		.p3SelData, .port3Data, .port3Out, .port3SelectReg, .port4In,
		.port5In, .irqEnable, .flagClear, .cpuIrqDisable, .irqFlags,
		.irqRequest, .nmiPulse, .asyncCtrl, .port6Data(8'h00),
		.port6Dir, .port6In, .uartTx, .timerATimeout,
		.tokenChainDrive(1'b0), .sendRequest, .messageBusy, .ackDrive,
		.port6Out, .port6Oe, .uartRx, .timerACountPulse, .chainGrant,
		.tokenLineIn);
	pafl_ext_model partner (.clk, .arst_n, .port6Out, .port6Oe, .rxBit,
		.extPull, .port6In);
	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] got);
		cmp_count++;
		if (got !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, got);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	// one bus cycle; outputs follow one edge later
	task automatic bus(input logic [7:0] bc, input logic [15:0] a,
		input logic wr, input logic in, input logic p2);
		@(posedge clk);
		busControl <= bc;
		cpu.addr <= a;
		cpu.wdata <= 8'h3c;
		cpu.rdata <= 8'hc3;
		cpu.write <= wr;
		cpu.internal <= in;
		cpu.valid <= 1'b1;
		phase2High <= p2;
		settle(1);
	endtask : bus
	task automatic selWrite(input logic [7:0] v);
		@(posedge clk);
		p3SelWrite <= 1'b1;
		p3SelData <= v;
		@(posedge clk);
		p3SelWrite <= 1'b0;
		settle(0);
	endtask : selWrite
	task automatic pins(input logic [7:0] v4, input logic [7:0] v5);
		@(posedge clk);
		port4In <= v4;
		port5In <= v5;
		settle(1);
	endtask : pins
	task automatic clr(input pafl_flags_t f);
		@(posedge clk);
		flagClear <= f;
		@(posedge clk);
		flagClear <= '0;
		settle(0);
	endtask : clr
	initial
	begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		settle(1);
		chk("select reset", 16'h0080, 16'(port3SelectReg));
		bus(8'h81, 16'h1234, 1'b1, 1'b1, 1'b1);
		chk("addr normal", 16'hffff, addrOut);
		chk("data normal", 16'h00ff, 16'(dataOut));
		bus(8'h89, 16'h1234, 1'b1, 1'b1, 1'b1);
		chk("addr trace", 16'h1234, addrOut);
		chk("addr enable", 16'h0001, 16'(addrOe));
		chk("data trace wr", 16'h003c, 16'(dataOut));
		bus(8'h89, 16'h0042, 1'b0, 1'b1, 1'b1);
		chk("data trace rd", 16'h00c3, 16'(dataOut));
		bus(8'h81, 16'h8000, 1'b1, 1'b0, 1'b0);
		chk("data float low", 16'h0000, 16'(dataOe));
		bus(8'h81, 16'h8000, 1'b1, 1'b0, 1'b1);
		chk("data drive high", 16'h0001, 16'(dataOe));
		$display("test bus done");
		selWrite(8'hff);
		chk("select reg", 16'h00ff, 16'(port3SelectReg));
		for (int i = 0; i < 8; i++)
			for (int p = 0; p < 2; p++)
			begin
				bus(8'h00, 16'(i << 13), 1'b0, 1'b0, p[0]);
				exp = (p == 1 || i < 3) ? ~(8'h01 << i) : 8'hff;
				chk("chip select", 16'(exp), 16'(port3Out));
			end
		selWrite(8'h00);
		bus(8'h00, 16'h0000, 1'b0, 1'b0, 1'b1);
		chk("port3 data", 16'h00a5, 16'(port3Out));
		chk("addr released", 16'h0000, 16'(addrOe));
		bus(8'h80, 16'he000, 1'b0, 1'b0, 1'b1);
		chk("select seven", 16'h0025, 16'(port3Out));
		$display("test selects done");
		bus(8'h40, 16'h0000, 1'b0, 1'b0, 1'b0);
		clr('1);
		pins(8'hdf, 8'h8c);
		chk("rise flag", 16'h0080, 16'(irqFlags));
		chk("request", 16'h0001, 16'(irqRequest));
		settle(3);
		chk("flag held", 16'h0080, 16'(irqFlags));
		@(posedge clk);
		cpuIrqDisable <= 1'b1;
		settle(1);
		chk("request masked", 16'h0000, 16'(irqRequest));
		clr(14'h0080);
		pins(8'hcf, 8'h8c);
		chk("rise on fall", 16'h0000, 16'(irqFlags));
		pins(8'h8f, 8'h8c);
		chk("fall flag", 16'h0004, 16'(irqFlags));
		clr(14'h0004);
		pins(8'hcf, 8'h8c);
		chk("fall on rise", 16'h0000, 16'(irqFlags));
		pins(8'hce, 8'h8c);
		chk("nmi pulse", 16'h0001, 16'(nmiPulse));
		settle(1);
		chk("nmi single", 16'h0000, 16'(nmiPulse));
		pins(8'hcc, 8'h8c);
		chk("level flag", 16'h0001, 16'(irqFlags));
		clr(14'h0001);
		chk("level held", 16'h0001, 16'(irqFlags));
		@(posedge clk);
		cpuIrqDisable <= 1'b0;
		settle(1);
		chk("level request", 16'h0001, 16'(irqRequest));
		pins(8'hcf, 8'h8c);
		clr(14'h0001);
		chk("level cleared", 16'h0000, 16'(irqFlags));
		pins(8'hcf, 8'hcc);
		chk("port5 rise", 16'h2000, 16'(irqFlags));
		@(posedge clk);
		irqEnable <= '0;
		settle(1);
		chk("request gated", 16'h0000, 16'(irqRequest));
		$display("test interrupts done");
		@(posedge clk);
		uartTx <= 1'b1;
		rxBit <= 1'b0;
		settle(1);
		chk("tx pin", 16'h0003, 16'({port6Oe[1], port6Out[1]}));
		chk("rx pin", 16'h0000, 16'(uartRx));
		chk("rx released", 16'h0000, 16'(port6Oe[0]));
		chk("chain in", 16'h0001, 16'(chainGrant));
		for (int i = 1; i < 3; i++)
		begin
			@(posedge clk);
			timerATimeout <= 1'b1;
			@(posedge clk);
			timerATimeout <= 1'b0;
			settle(0);
			chk("timer wave", 16'(i % 2), 16'(port6Out[3]));
		end
		cnt = 0;
		for (int i = 0; i < 8; i++)
		begin
			settle(1);
			cnt += timerACountPulse;
		end
		chk("count pulses", 16'h0002, 16'(cnt));
		@(posedge clk);
		sendRequest <= 1'b1;
		settle(2);
		chk("start pull", 16'h0004, 16'({port6Oe[6], port6Out[6],
			tokenLineIn}));
		@(posedge clk);
		sendRequest <= 1'b0;
		messageBusy <= 1'b1;
		ackDrive <= 1'b1;
		settle(2);
		chk("ack pull", 16'h0004, 16'({port6Oe[6], port6Out[6],
			tokenLineIn}));
		@(posedge clk);
		ackDrive <= 1'b0;
		extPull <= 1'b1;
		// busy line: a new send request must not pull
		sendRequest <= 1'b1;
		settle(2);
		chk("line seen low", 16'h0000, 16'({port6Oe[6], tokenLineIn}));
		$display("test port6 done");
		results();
	end
	initial
	begin
		#100us;
		fails++;
		results();
	end
endmodule : tb_top
